// file: bench/pmqm_mac_model.sv
`timescale 1ns/1ps
module pmqm_mac_model (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      fail_i,
	input  wire pmqm_pkg::pmqm_txmac_out_t txmac_o,
	output pmqm_pkg::pmqm_txmac_in_t       txmac_i
);
	logic [3:0]  cnt;
	logic        busy;
	logic [15:0] lfsr;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			lfsr <= 16'hACE1;
			txmac_i <= '0;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			txmac_i.done <= 1'b0;
			txmac_i.fail <= 1'b0;
			// deferral opens at random, so half duplex stalls the queue now and then
			txmac_i.defer_ok <= lfsr[3];
			if (txmac_o.start) begin
				busy <= 1'b1;
				cnt <= {2'b00, lfsr[1:0]} + 4'h2;
				txmac_i.rd_addr <= '0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
				txmac_i.rd_addr <= txmac_i.rd_addr + 9'h001;
				if (cnt == 4'h1) begin
					busy <= 1'b0;
					txmac_i.done <= !fail_i;
					txmac_i.fail <= fail_i;
				end
			end
		end
	end
endmodule : pmqm_mac_model

// file: bench/pmqm_properties.sv
`timescale 1ns/1ps
module pmqm_properties #(
	parameter int NUM_PAGES = 8
) (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_we_i,
	input wire logic [7:0]                wb_adr_i,
	input wire logic [3:0]                wb_sel_i,
	input wire logic [31:0]               wb_dat_i,
	input wire logic [31:0]               wb_dat_o,
	input wire logic                      wb_ack_o,
	input wire logic                      irq_o,
	input wire pmqm_pkg::pmqm_txmac_in_t  txmac_i,
	input wire pmqm_pkg::pmqm_txmac_out_t txmac_o,
	input wire pmqm_pkg::pmqm_rxmac_in_t  rxmac_i,
	input wire pmqm_pkg::pmqm_mem_wr_t    mem_o
);
	logic [4:0] ctrl_m;
	logic [3:0] mask_m;
	logic       act;
	wire logic  take = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & (wb_sel_i == 4'hF);
	// mirrors follow the write at its taking edge, as the register does
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_m <= 5'h00;
			mask_m <= 4'h0;
			act <= 1'b0;
		end else begin
			if (take && wb_adr_i == pmqm_pkg::REG_CTRL)
				ctrl_m <= wb_dat_i[4:0];
			else if (txmac_i.fail)
				ctrl_m[0] <= 1'b0;
			if (take && wb_adr_i == pmqm_pkg::REG_MASK)
				mask_m <= wb_dat_i[3:0];
			if (rxmac_i.start && ctrl_m[1])
				act <= 1'b1;
			else if (rxmac_i.eop || rxmac_i.overrun)
				act <= 1'b0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o && wb_dat_o == 32'h0)
		else $error("ack or read data held too long");
	chk_tx_enable: assert property (txmac_o.start |-> ctrl_m[0] || $past(ctrl_m[0]))
		else $error("transmit started while disabled");
	chk_tx_xlate: assert property (txmac_o.start ##3 1'b1
		|-> txmac_o.rd_phys[5:0] == $past(txmac_i.rd_addr[5:0]))
		else $error("transmit read address offset not carried through");
	chk_fail_stop: assert property (txmac_i.fail |=> !txmac_o.start [*4])
		else $error("transmit continued after failure");
	chk_rx_gate: assert property (mem_o.we |-> ctrl_m[1])
		else $error("receive write while receive disabled");
	chk_rx_word: assert property (act && rxmac_i.valid |=> mem_o.we
		&& mem_o.addr[5:0] >= 6'h02 && mem_o.data == $past(rxmac_i.data))
		else $error("receive word not written at its logical place");
	chk_rx_tail: assert property (act && rxmac_i.eop |-> ##2 mem_o.we && mem_o.addr[5:0] == 6'h00
		&& mem_o.data[15:0] == $past(rxmac_i.status, 2) ##1 mem_o.we
		&& mem_o.addr[5:0] == 6'h01 && mem_o.data[15:0] == $past(rxmac_i.bytes, 3))
		else $error("status or byte count misplaced");
	chk_ovr_drop: assert property (act && rxmac_i.overrun |=> !mem_o.we [*4])
		else $error("write after overrun");
	chk_irq_mask: assert property (mask_m == 4'h0 && $past(mask_m) == 4'h0 |-> !irq_o)
		else $error("interrupt with all sources masked");
	cov_tx_start: cover property (txmac_o.start);
	cov_tx_fail: cover property (txmac_i.fail);
	cov_rx_eop: cover property (act && rxmac_i.eop);
	cov_irq: cover property (irq_o);
endmodule : pmqm_properties

bind pmqm_top pmqm_properties #(.NUM_PAGES(NUM_PAGES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_o(irq_o), .txmac_i(txmac_i), .txmac_o(txmac_o), .rxmac_i(rxmac_i), .mem_o(mem_o));

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
	logic                      clk_i = 1'b0;
	logic                      rst_i = 1'b1;
	logic                      cyc = 1'b0;
	logic                      stb = 1'b0;
	logic                      we = 1'b0;
	logic [7:0]                adr = 8'h00;
	logic [3:0]                sel = 4'hF;
	logic [31:0]               wdat = 32'h0;
	logic [31:0]               rdat;
	logic                      ack;
	logic                      irq;
	logic                      fail_req = 1'b0;
	pmqm_pkg::pmqm_txmac_in_t  txi;
	pmqm_pkg::pmqm_txmac_out_t txo;
	pmqm_pkg::pmqm_rxmac_in_t  rxi = '0;
	pmqm_pkg::pmqm_mem_wr_t    mem;
	int                        err_count = 0;
	int                        check_count = 0;
	int                        free_pages;
	int                        n;
	int                        rxq[$];
	logic [31:0]               seed = 32'h9E99;
	logic [31:0]               q;
	logic [2:0]                pa;
	logic [2:0]                last_pkt = 3'h0;
	logic                      exp;

	pmqm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq_o(irq), .txmac_i(txi), .txmac_o(txo), .rxmac_i(rxi), .mem_o(mem));
	pmqm_mac_model u_mac (.clk_i(clk_i), .rst_i(rst_i), .fail_i(fail_req), .txmac_o(txo),
		.txmac_i(txi));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (txo.start === 1'b1) last_pkt <= txo.pkt;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int pg(int b);
		return (b + pmqm_pkg::HDR_BYTES + 255) / 256;
	endfunction : pg
	task automatic check(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic report_and_stop();
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// one classic cycle; the request holds until ack is sampled high
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 40) check("wb_ack", 32'h1, {31'h0, ack});
	endtask : wb
	task automatic rchk(string nm, logic [7:0] a, logic [31:0] m, logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(nm, e, q & m);
	endtask : rchk
	task automatic poll(string nm, logic [7:0] a, logic [31:0] m, logic [31:0] e);
		int k;
		k = 0;
		do begin
			wb(1'b0, a, 32'h0);
			k++;
		end while ((q & m) !== e && k < 60);
		check(nm, e, q & m);
	endtask : poll
	task automatic cmd(logic [2:0] c, int b);
		wb(1'b1, pmqm_pkg::REG_CMD, {16'(b), 13'h0000, c});
	endtask : cmd
	task automatic frame(int k, logic ok, logic ovr);
		@(posedge clk_i) rxi.start <= 1'b1;
		for (int j = 0; j < k; j++) begin
			@(posedge clk_i) rxi.start <= 1'b0;
			rxi.valid <= 1'b1;
			rxi.data <= rnd();
			@(posedge clk_i) rxi.valid <= 1'b0;
		end
		@(posedge clk_i) rxi.eop <= !ovr;
		rxi.overrun <= ovr;
		rxi.crc_ok <= ok;
		rxi.status <= 16'(rnd());
		rxi.bytes <= 16'(k * 4);
		@(posedge clk_i) rxi.eop <= 1'b0;
		rxi.overrun <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : frame

	initial begin
		#300000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		free_pages = 8;
		rchk("ctrl", pmqm_pkg::REG_CTRL, 32'h1F, 32'h0);
		rchk("stat", pmqm_pkg::REG_STAT, 32'hF, 32'h4);
		rchk("free", pmqm_pkg::REG_FREE, 32'hFF, 32'h8);
		rchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
		// a write on only some byte lanes must leave the register alone
		sel <= 4'h3;
		wb(1'b1, pmqm_pkg::REG_CTRL, 32'h1F);
		sel <= 4'hF;
		rchk("part_wr", pmqm_pkg::REG_CTRL, 32'h1F, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, pmqm_pkg::REG_CTRL, 32'h4);
			n = int'(rnd() % 1500) + 1;
			cmd(pmqm_pkg::CMD_ALLOC, n);
			poll("alloc_done", pmqm_pkg::REG_STAT, 32'h1, 32'h1);
			rchk("alloc_ok", pmqm_pkg::REG_ALLOC, 32'h80000000, 32'h0);
			pa = q[2:0];
			free_pages -= pg(n);
			rchk("free", pmqm_pkg::REG_FREE, 32'hFF, free_pages);
			wb(1'b1, pmqm_pkg::REG_STAT, 32'h1);
			wb(1'b1, pmqm_pkg::REG_PNR, {29'h0, pa});
			cmd(pmqm_pkg::CMD_ENQ, 0);
			rchk("held", pmqm_pkg::REG_STAT, 32'h4, 32'h0);
			fail_req <= (i == 2);
			wb(1'b1, pmqm_pkg::REG_CTRL, (i == 1) ? 32'h15 : 32'h5);
			if (i == 2) begin
				poll("tx_int", pmqm_pkg::REG_STAT, 32'h2, 32'h2);
				rchk("txen_off", pmqm_pkg::REG_CTRL, 32'h1, 32'h0);
				rchk("fail_num", pmqm_pkg::REG_FIFO, 32'h87, {29'h0, pa});
				fail_req <= 1'b0;
				wb(1'b1, pmqm_pkg::REG_PNR, {29'h0, pa});
				cmd(pmqm_pkg::CMD_ENQ, 0);
				wb(1'b1, pmqm_pkg::REG_CTRL, 32'h5);
			end
			free_pages += pg(n);
			poll("freed", pmqm_pkg::REG_FREE, 32'hFF, free_pages);
			check("tx_pkt", {29'h0, pa}, {29'h0, last_pkt});
			if (i == 2) cmd(pmqm_pkg::CMD_TXACK, 0);
			rchk("tx_done", pmqm_pkg::REG_STAT, 32'h6, 32'h4);
		end
		cmd(pmqm_pkg::CMD_ALLOC, 2040);
		poll("big_alloc", pmqm_pkg::REG_STAT, 32'h1, 32'h1);
		rchk("big_num", pmqm_pkg::REG_ALLOC, 32'h80000000, 32'h0);
		pa = q[2:0];
		cmd(pmqm_pkg::CMD_ALLOC, 100);
		rchk("alloc_wait", pmqm_pkg::REG_ALLOC, 32'h80000000, 32'h80000000);
		rchk("flag_clear", pmqm_pkg::REG_STAT, 32'h1, 32'h0);
		wb(1'b1, pmqm_pkg::REG_PNR, {29'h0, pa});
		cmd(pmqm_pkg::CMD_REL, 0);
		poll("late_alloc", pmqm_pkg::REG_STAT, 32'h1, 32'h1);
		rchk("late_num", pmqm_pkg::REG_ALLOC, 32'h80000000, 32'h0);
		wb(1'b1, pmqm_pkg::REG_PNR, {29'h0, q[2:0]});
		cmd(pmqm_pkg::CMD_REL, 0);
		poll("all_free", pmqm_pkg::REG_FREE, 32'hFF, 32'h8);
		wb(1'b1, pmqm_pkg::REG_MASK, 32'h8);
		// good, bad crc dropped, bad crc kept, overrun, receive disabled
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, pmqm_pkg::REG_CTRL, (i == 2) ? 32'hA : (i == 4) ? 32'h0 : 32'h2);
			frame(int'(rnd() % 4) + 1, i == 0, i == 3);
			exp = (i == 0 || i == 2);
			if (exp) rxq.push_back(i);
			rchk("rx_flag", pmqm_pkg::REG_STAT, 32'h8, exp ? 32'h8 : 32'h0);
			check("irq", {31'h0, exp}, {31'h0, irq});
			rchk("rx_fifo", pmqm_pkg::REG_FIFO, 32'h8000, exp ? 32'h0 : 32'h8000);
			rchk("rx_free", pmqm_pkg::REG_FREE, 32'hFF, exp ? 32'h7 : 32'h8);
			if (exp) begin
				cmd(pmqm_pkg::CMD_RXREL, 0);
				void'(rxq.pop_front());
				poll("rx_rel", pmqm_pkg::REG_FREE, 32'hFF, 32'h8);
			end
		end
		// more than the whole memory can never be granted
		cmd(pmqm_pkg::CMD_ALLOC, 4000);
		rchk("huge_wait", pmqm_pkg::REG_ALLOC, 32'h80000000, 32'h80000000);
		wb(1'b1, pmqm_pkg::REG_MASK, 32'h0);
		check("rx_queue", 32'h0, rxq.size());
		report_and_stop();
	end
endmodule : tb

// file: core/pmqm_pkg.sv
package pmqm_pkg;
	localparam int PKT_W      = 3;
	localparam int NPKT       = 8;
	localparam int PAGE_W     = 3;
	localparam int NPAGE      = 8;
	localparam int WOFF_W     = 6;
	localparam int ADDR_W     = PAGE_W + WOFF_W;
	localparam int PAGE_BYTES = 256;
	localparam int PAGE_SHIFT = 8;
	localparam int HDR_BYTES  = 4;

	localparam logic [7:0] REG_CMD   = 8'h00;
	localparam logic [7:0] REG_CTRL  = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_MASK  = 8'h0C;
	localparam logic [7:0] REG_ALLOC = 8'h10;
	localparam logic [7:0] REG_PNR   = 8'h14;
	localparam logic [7:0] REG_FIFO  = 8'h18;
	localparam logic [7:0] REG_FREE  = 8'h1C;

	localparam logic [2:0] CMD_ALLOC = 3'h1;
	localparam logic [2:0] CMD_ENQ   = 3'h2;
	localparam logic [2:0] CMD_REL   = 3'h3;
	localparam logic [2:0] CMD_RXREL = 3'h4;
	localparam logic [2:0] CMD_TXACK = 3'h5;

	localparam int CTRL_TXEN    = 0;
	localparam int CTRL_RECEIVE_ENABLE_BIT    = 1;
	localparam int CTRL_AUTOREL = 2;
	localparam int CTRL_BADCRC  = 3;
	localparam int CTRL_HALFDUP = 4;
	localparam int ST_ALLOC     = 0;
	localparam int ST_TX        = 1;
	localparam int ST_TRANSMIT_QUEUE_EMPTY_FLAG   = 2;
	localparam int ST_RCV       = 3;
	localparam int FIFO_RX_LSB  = 8;
	localparam int FIFO_RXE_BIT = 15;
	localparam int FIFO_TXE_BIT = 7;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [3:0] MASK_RST = 4'h0;

	typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_STAT, RX_CNT} pmqm_rx_state_t;

	typedef struct packed {
		logic [NPKT-1:0][PKT_W-1:0] slot;
		logic [PKT_W-1:0]           rd;
		logic [PKT_W-1:0]           wr;
		logic [PKT_W:0]             cnt;
	} pmqm_q_t;

	typedef struct packed {
		logic              done;
		logic              fail;
		logic              defer_ok;
		logic [ADDR_W-1:0] rd_addr;
	} pmqm_txmac_in_t;

	typedef struct packed {
		logic              start;
		logic [PKT_W-1:0]  pkt;
		logic [ADDR_W-1:0] rd_phys;
	} pmqm_txmac_out_t;

	typedef struct packed {
		logic        start;
		logic        valid;
		logic [31:0] data;
		logic        overrun;
		logic        eop;
		logic        crc_ok;
		logic [15:0] status;
		logic [15:0] bytes;
	} pmqm_rxmac_in_t;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       data;
	} pmqm_mem_wr_t;
endpackage : pmqm_pkg

// file: core/pmqm_top.sv
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pmqm_top #(
	parameter int NUM_PAGES = pmqm_pkg::NPAGE
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	output logic                          irq_o,
	input  wire pmqm_pkg::pmqm_txmac_in_t txmac_i,
	output pmqm_pkg::pmqm_txmac_out_t     txmac_o,
	input  wire pmqm_pkg::pmqm_rxmac_in_t rxmac_i,
	output pmqm_pkg::pmqm_mem_wr_t        mem_o
);
	localparam int PW = pmqm_pkg::PKT_W;
	localparam int GW = pmqm_pkg::PAGE_W;
	localparam int AW = pmqm_pkg::ADDR_W;

	if (NUM_PAGES != pmqm_pkg::NPAGE) begin : g_bad_pages
		$error("NUM_PAGES must match the page table size");
	end

	typedef struct packed {
		logic                                ack;
		logic [31:0]                         dat;
		logic [4:0]                          ctrl;
		logic [3:0]                          mask;
		logic                                alloc_flag;
		logic                                alloc_busy;
		logic [GW:0]                         alloc_need;
		logic [PW-1:0]                       alloc_res;
		logic [PW-1:0]                       packet_number_register;
		logic [pmqm_pkg::NPAGE-1:0]          pg_used;
		logic [pmqm_pkg::NPAGE-1:0][PW-1:0]  pg_own;
		logic [pmqm_pkg::NPAGE-1:0][GW-1:0]  pg_seq;
		logic [pmqm_pkg::NPKT-1:0]           pk_used;
		pmqm_pkg::pmqm_q_t                   txq;
		pmqm_pkg::pmqm_q_t                   cq;
		pmqm_pkg::pmqm_q_t                   rxq;
		logic                                tx_busy;
		logic [PW-1:0]                       tx_cur;
		pmqm_pkg::pmqm_txmac_out_t           txo;
		pmqm_pkg::pmqm_rx_state_t            rx_st;
		logic [PW-1:0]                       rx_pkt;
		logic [AW-1:0]                       rx_widx;
		logic [GW:0]                         rx_pages;
		logic [15:0]                         rx_stat;
		logic [15:0]                         rx_bytes;
		logic                                rx_keep;
		pmqm_pkg::pmqm_mem_wr_t              mem;
		logic                                irq;
	} pmqm_state_t;

	pmqm_state_t s;
	pmqm_state_t next_s;

	function automatic pmqm_pkg::pmqm_q_t q_push(pmqm_pkg::pmqm_q_t q, logic [PW-1:0] v);
		q.slot[q.rd + q.cnt[PW-1:0]] = v;
		q.cnt = q.cnt + 1'b1;
		return q;
	endfunction : q_push

	function automatic pmqm_pkg::pmqm_q_t q_pop(pmqm_pkg::pmqm_q_t q);
		q.rd  = q.rd + 1'b1;
		q.cnt = q.cnt - 1'b1;
		return q;
	endfunction : q_pop

	function automatic int first_free(logic [pmqm_pkg::NPAGE-1:0] used);
		int r;
		r = -1;
		for (int i = pmqm_pkg::NPAGE - 1; i >= 0; i--) begin
			if (!used[i]) begin
				r = i;
			end
		end
		return r;
	endfunction : first_free

	function automatic int first_free_pkt(logic [pmqm_pkg::NPKT-1:0] used);
		int r;
		r = -1;
		for (int i = pmqm_pkg::NPKT - 1; i >= 0; i--) begin
			if (!used[i]) begin
				r = i;
			end
		end
		return r;
	endfunction : first_free_pkt

	function automatic int free_pages(logic [pmqm_pkg::NPAGE-1:0] used);
		int c;
		c = 0;
		for (int i = 0; i < pmqm_pkg::NPAGE; i++) begin
			c = c + int'(!used[i]);
		end
		return c;
	endfunction : free_pages

	// logical word address of a packet to its physical page location
	function automatic logic [AW-1:0] xlate(pmqm_state_t t, logic [PW-1:0] pk, logic [AW-1:0] la);
		logic [AW-1:0] r;
		r = '0;
		for (int i = 0; i < pmqm_pkg::NPAGE; i++) begin
			if (t.pg_used[i] && t.pg_own[i] == pk && t.pg_seq[i] == la[AW-1:pmqm_pkg::WOFF_W]) begin
				r = {GW'(i), la[pmqm_pkg::WOFF_W-1:0]};
			end
		end
		return r;
	endfunction : xlate

	function automatic pmqm_state_t release_pkt(pmqm_state_t t, logic [PW-1:0] pk);
		for (int i = 0; i < pmqm_pkg::NPAGE; i++) begin
			if (t.pg_own[i] == pk) begin
				t.pg_used[i] = 1'b0;
			end
		end
		t.pk_used[pk] = 1'b0;
		return t;
	endfunction : release_pkt

	always_comb begin
		int            fp;
		int            fk;
		int            nfree;
		logic [16:0]   bytes_up;
		logic [2:0]    cmd;
		logic          wr;
		logic          rx_page_taken;
		logic [31:0]   rdv;
		fp            = 0;
		fk            = 0;
		nfree         = 0;
		bytes_up      = '0;
		cmd           = '0;
		rx_page_taken = 1'b0;
		rdv           = '0;
		next_s        = s;
		next_s.txo.start = 1'b0;
		next_s.mem.we    = 1'b0;

		// bus: one wait state, every access acknowledged; partial writes ignored
		wr  = wb_cyc_i && wb_stb_i && !s.ack && wb_we_i && (wb_sel_i == 4'hF);
		cmd = wb_dat_i[2:0];
		next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
		if (wr) begin
			case (wb_adr_i)
				pmqm_pkg::REG_CTRL: next_s.ctrl = wb_dat_i[4:0];
				pmqm_pkg::REG_MASK: next_s.mask = wb_dat_i[3:0];
				pmqm_pkg::REG_PNR:  next_s.packet_number_register  = wb_dat_i[PW-1:0];
				pmqm_pkg::REG_STAT: begin
					if (wb_dat_i[pmqm_pkg::ST_ALLOC]) begin
						next_s.alloc_flag = 1'b0;
					end
				end
				pmqm_pkg::REG_CMD: begin
					case (cmd)
						pmqm_pkg::CMD_ALLOC: begin
							bytes_up = {1'b0, wb_dat_i[31:16]} + 17'(pmqm_pkg::HDR_BYTES)
								+ 17'(pmqm_pkg::PAGE_BYTES - 1);
							next_s.alloc_need = (GW + 1)'(bytes_up >> pmqm_pkg::PAGE_SHIFT);
							if ((bytes_up >> pmqm_pkg::PAGE_SHIFT) > 17'(pmqm_pkg::NPAGE)) begin
								next_s.alloc_need = '1;
							end
							next_s.alloc_busy = 1'b1;
							next_s.alloc_flag = 1'b0;
						end
						pmqm_pkg::CMD_ENQ: begin
							if (!s.txq.cnt[PW]) begin
								next_s.txq = q_push(s.txq, s.packet_number_register);
							end
						end
						pmqm_pkg::CMD_REL: next_s = release_pkt(next_s, s.packet_number_register);
						pmqm_pkg::CMD_RXREL: begin
							if (s.rxq.cnt != '0) begin
								next_s     = release_pkt(next_s, s.rxq.slot[s.rxq.rd]);
								next_s.rxq = q_pop(s.rxq);
							end
						end
						pmqm_pkg::CMD_TXACK: begin
							if (s.cq.cnt != '0) begin
								next_s.cq = q_pop(s.cq);
							end
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end

		// transmit engine
		if (s.tx_busy && (txmac_i.done || txmac_i.fail)) begin
			next_s.tx_busy = 1'b0;
			next_s.txq     = q_pop(next_s.txq);
			if (txmac_i.fail) begin
				next_s.cq = q_push(next_s.cq, s.tx_cur);
				next_s.ctrl[pmqm_pkg::CTRL_TXEN] = 1'b0;
			end else if (s.ctrl[pmqm_pkg::CTRL_AUTOREL]) begin
				next_s = release_pkt(next_s, s.tx_cur);
			end else begin
				next_s.cq = q_push(next_s.cq, s.tx_cur);
			end
		end else if (!s.tx_busy && s.txq.cnt != '0 && s.ctrl[pmqm_pkg::CTRL_TXEN]
			&& (!s.ctrl[pmqm_pkg::CTRL_HALFDUP] || txmac_i.defer_ok)) begin
			next_s.tx_busy   = 1'b1;
			next_s.tx_cur    = s.txq.slot[s.txq.rd];
			next_s.txo.start = 1'b1;
			next_s.txo.pkt   = s.txq.slot[s.txq.rd];
		end
		next_s.txo.rd_phys = xlate(s, s.tx_cur, txmac_i.rd_addr);

		// receive engine
		case (s.rx_st)
			pmqm_pkg::RX_IDLE: begin
				fp = first_free(next_s.pg_used);
				fk = first_free_pkt(next_s.pk_used);
				if (rxmac_i.start && s.ctrl[pmqm_pkg::CTRL_RECEIVE_ENABLE_BIT] && fp >= 0 && fk >= 0) begin
					next_s.rx_pkt      = PW'(fk);
					next_s.pk_used[fk] = 1'b1;
					next_s.pg_used[fp] = 1'b1;
					next_s.pg_own[fp]  = PW'(fk);
					next_s.pg_seq[fp]  = '0;
					next_s.rx_pages    = (GW + 1)'(1);
					next_s.rx_widx     = AW'(2);
					next_s.rx_st       = pmqm_pkg::RX_DATA;
					rx_page_taken      = 1'b1;
				end
			end
			pmqm_pkg::RX_DATA: begin
				fp = first_free(next_s.pg_used);
				if (rxmac_i.overrun) begin
					next_s       = release_pkt(next_s, s.rx_pkt);
					next_s.rx_st = pmqm_pkg::RX_IDLE;
				end else if (rxmac_i.eop) begin
					next_s.rx_stat  = rxmac_i.status;
					next_s.rx_bytes = rxmac_i.bytes;
					next_s.rx_keep  = rxmac_i.crc_ok || s.ctrl[pmqm_pkg::CTRL_BADCRC];
					next_s.rx_st    = pmqm_pkg::RX_STAT;
				end else if (rxmac_i.valid) begin
					if ({1'b0, s.rx_widx[AW-1:pmqm_pkg::WOFF_W]} == s.rx_pages) begin
						if (fp < 0 || s.rx_pages[GW]) begin
							// no page left behaves as an overrun
							next_s       = release_pkt(next_s, s.rx_pkt);
							next_s.rx_st = pmqm_pkg::RX_IDLE;
						end else begin
							next_s.pg_used[fp] = 1'b1;
							next_s.pg_own[fp]  = s.rx_pkt;
							next_s.pg_seq[fp]  = s.rx_pages[GW-1:0];
							next_s.rx_pages    = s.rx_pages + 1'b1;
							rx_page_taken      = 1'b1;
						end
					end
					if (next_s.rx_st == pmqm_pkg::RX_DATA) begin
						next_s.mem.we   = 1'b1;
						next_s.mem.addr = xlate(next_s, s.rx_pkt, s.rx_widx);
						next_s.mem.data = rxmac_i.data;
						next_s.rx_widx  = s.rx_widx + 1'b1;
					end
				end
			end
			pmqm_pkg::RX_STAT: begin
				next_s.mem.we   = 1'b1;
				next_s.mem.addr = xlate(s, s.rx_pkt, AW'(0));
				next_s.mem.data = {16'h0000, s.rx_stat};
				next_s.rx_st    = pmqm_pkg::RX_CNT;
			end
			pmqm_pkg::RX_CNT: begin
				next_s.mem.we   = 1'b1;
				next_s.mem.addr = xlate(s, s.rx_pkt, AW'(1));
				next_s.mem.data = {16'h0000, s.rx_bytes};
				next_s.rx_st    = pmqm_pkg::RX_IDLE;
				if (s.rx_keep && !next_s.rxq.cnt[PW]) begin
					next_s.rxq = q_push(next_s.rxq, s.rx_pkt);
				end else begin
					next_s = release_pkt(next_s, s.rx_pkt);
				end
			end
			default: next_s.rx_st = pmqm_pkg::RX_IDLE;
		endcase

		// receive has priority; transmit allocation retries every cycle until it fits
		nfree = free_pages(next_s.pg_used);
		fk    = first_free_pkt(next_s.pk_used);
		if (s.alloc_busy && !rx_page_taken && fk >= 0 && nfree >= int'(s.alloc_need)) begin
			next_s.alloc_busy  = 1'b0;
			next_s.alloc_flag  = 1'b1;
			next_s.alloc_res   = PW'(fk);
			next_s.pk_used[fk] = 1'b1;
			for (int k = 0; k < pmqm_pkg::NPAGE; k++) begin
				fp = first_free(next_s.pg_used);
				if (k < int'(s.alloc_need) && fp >= 0) begin
					next_s.pg_used[fp] = 1'b1;
					next_s.pg_own[fp]  = PW'(fk);
					next_s.pg_seq[fp]  = GW'(k);
				end
			end
		end

		rdv[pmqm_pkg::ST_ALLOC]   = next_s.alloc_flag;
		rdv[pmqm_pkg::ST_TX]      = next_s.cq.cnt != '0;
		rdv[pmqm_pkg::ST_TRANSMIT_QUEUE_EMPTY_FLAG] = next_s.txq.cnt == '0;
		rdv[pmqm_pkg::ST_RCV]     = next_s.rxq.cnt != '0;
		next_s.irq = |(rdv[3:0] & next_s.mask);

		next_s.dat = '0;
		if (wb_cyc_i && wb_stb_i && !s.ack && !wb_we_i) begin
			case (wb_adr_i)
				pmqm_pkg::REG_CTRL:  next_s.dat = {27'h0, s.ctrl};
				pmqm_pkg::REG_MASK:  next_s.dat = {28'h0, s.mask};
				pmqm_pkg::REG_STAT:  next_s.dat = {28'h0, rdv[3:0]};
				pmqm_pkg::REG_ALLOC: next_s.dat = {~s.alloc_flag, 28'h0, s.alloc_res};
				pmqm_pkg::REG_PNR:   next_s.dat = {29'h0, s.packet_number_register};
				pmqm_pkg::REG_FREE:  next_s.dat = 32'(free_pages(s.pg_used));
				pmqm_pkg::REG_FIFO: begin
					next_s.dat[PW-1:0] = s.cq.slot[s.cq.rd];
					next_s.dat[pmqm_pkg::FIFO_TXE_BIT] = s.cq.cnt == '0;
					next_s.dat[pmqm_pkg::FIFO_RX_LSB +: PW] = s.rxq.slot[s.rxq.rd];
					next_s.dat[pmqm_pkg::FIFO_RXE_BIT] = s.rxq.cnt == '0;
				end
				default: next_s.dat = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s       <= '0;
			s.ctrl  <= pmqm_pkg::CTRL_RST;
			s.mask  <= pmqm_pkg::MASK_RST;
			s.rx_st <= pmqm_pkg::RX_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// every output is a field of the registered state
	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign irq_o    = s.irq;
	assign txmac_o  = s.txo;
	assign mem_o    = s.mem;
endmodule : pmqm_top
